// ---- rtl/miep_irq_ctrl.v ----
`timescale 1ns/100ps
`default_nettype none
`include "mieprio_consts.vh"
module miep_irq_ctrl #(
  parameter PCW = 21,
  parameter NPER = 29
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [2:0] ext_pin_i,
  input wire [3:0] port_b_hi_i,
  input wire [NPER-1:0] periph_req_i,
  input wire sleeping_i,
  input wire entry_i,
  input wire [PCW-1:0] ret_pc_i,
  input wire [7:0] working_register_i,
  input wire [7:0] status_i,
  input wire [7:0] bsr_i,
  output reg irq_high_o,
  output reg irq_low_o,
  output reg wake_o,
  output reg wake_vector_o,
  output wire stack_push_o,
  output wire [PCW-1:0] stack_pc_o,
  output wire [7:0] shadow_working_register_o,
  output wire [7:0] shadow_status_o,
  output wire [7:0] shadow_bsr_o
);
  // peripheral request order: [28:26] extra_timer_irq_enable srcs, [25:23] capture_unit_irq_enable_b srcs,
  // [22:15] prio3 srcs, [14:7] prio2 srcs, [6:0] prio1 srcs
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] capture_unit_irq_enable_b_ff;
  reg [7:0] extra_timer_irq_enable_ff;
  reg [7:0] irq_priority_select_1_ff;
  reg [7:0] irq_priority_select_2_ff;
  reg [7:0] irq_priority_select_3_ff;
  reg [7:0] irq_priority_select_4_ff;
  reg [7:0] irq_priority_select_5_ff;
  reg [7:0] irq_control_primary_ff;
  reg [7:0] irq_control_second_ff;
  reg [7:0] irq_control_third_ff;
  reg [7:0] per_pin_change_enable_ff;
  reg [5:0] src_flag_ff;
  reg [7:0] timer_zero_counter_lo_ff;
  reg [7:0] timer_zero_counter_hi_ff;
  reg [1:0] t0_cfg_ff;
  reg [3:0] port_prev_ff;
  reg [7:0] rd_mux;
  wire [2:0] pin_edge;
  wire wr_strobe;
  wire [7:0] wr_byte;
  wire t0_ovf;
  wire port_change;
  wire [NPER-1:0] per_prio;
  wire [NPER-1:0] per_act;
  wire [2:0] pin_flag;
  wire [2:0] pin_en;
  wire [2:0] pin_prio;
  wire t0_req;
  wire pc_req;
  reg nxt_high;
  reg nxt_low;
  integer i;

  // writes land on the ack edge, where the master still holds the request
  assign wr_strobe = (state_ff == ST_ACK) & cyc_i & stb_i & we_i & sel_i[0];
  assign wr_byte = dat_i[7:0];

  // detector resets low, the idle level of the pins, so no false edge
  miep_edge_det #(
    .N(3)
  ) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_pin_i),
    .rising_i({irq_control_second_ff[`MIEP_C2_EDG2],
               irq_control_second_ff[`MIEP_C2_EDG1],
               irq_control_second_ff[`MIEP_C2_EDG0]}),
    .edge_o(pin_edge)
  );

  miep_ctx_save #(
    .PCW(PCW)
  ) u_ctx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .entry_i(entry_i),
    .ret_pc_i(ret_pc_i),
    .working_register_i(working_register_i),
    .status_i(status_i),
    .bsr_i(bsr_i),
    .push_o(stack_push_o),
    .push_pc_o(stack_pc_o),
    .shadow_working_register_o(shadow_working_register_o),
    .shadow_status_o(shadow_status_o),
    .shadow_bsr_o(shadow_bsr_o)
  );

  // timer zero overflow in the selected width
  assign t0_ovf = t0_cfg_ff[`MIEP_T0_RUN] &
    (timer_zero_counter_lo_ff == 8'hFF) &
    (~t0_cfg_ff[`MIEP_T0_16BIT] |
     (timer_zero_counter_hi_ff == 8'hFF));
  assign port_change = |((port_b_hi_i ^ port_prev_ff) &
    per_pin_change_enable_ff[7:4]);

  // wishbone slave: one wait state, ack for one cycle
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cyc_i & stb_i) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    case (adr_i)
      `MIEP_ADDR_CAP_EN_B: rd_mux = capture_unit_irq_enable_b_ff;
      `MIEP_ADDR_TMR_EN: rd_mux = extra_timer_irq_enable_ff;
      `MIEP_ADDR_PRIO1: rd_mux = irq_priority_select_1_ff;
      `MIEP_ADDR_PRIO2: rd_mux = irq_priority_select_2_ff;
      `MIEP_ADDR_PRIO3: rd_mux = irq_priority_select_3_ff;
      `MIEP_ADDR_PRIO4: rd_mux = irq_priority_select_4_ff;
      `MIEP_ADDR_PRIO5: rd_mux = irq_priority_select_5_ff;
      `MIEP_ADDR_CTRL1: rd_mux = irq_control_primary_ff;
      `MIEP_ADDR_CTRL2: rd_mux = irq_control_second_ff;
      `MIEP_ADDR_CTRL3: rd_mux = irq_control_third_ff;
      `MIEP_ADDR_IOC: rd_mux = per_pin_change_enable_ff;
      `MIEP_ADDR_SRCFLAG: rd_mux = {2'b00, src_flag_ff};
      `MIEP_ADDR_TMR0L: rd_mux = timer_zero_counter_lo_ff;
      `MIEP_ADDR_TMR0H: rd_mux = timer_zero_counter_hi_ff;
      `MIEP_ADDR_T0CON: rd_mux = {6'h00, t0_cfg_ff};
      `MIEP_ADDR_REQ: rd_mux = {6'h00, irq_low_o, irq_high_o};
      default: rd_mux = 8'h00;
    endcase
  end

  // priority routing: 1 sends a source to the high line
  assign per_prio = {irq_priority_select_5_ff[2:0],
                     irq_priority_select_4_ff[2:0],
                     irq_priority_select_3_ff,
                     irq_priority_select_2_ff,
                     irq_priority_select_1_ff[6:0]};
  // only the upper-range peripheral enables live here; lower sources arrive
  // already gated, so their request lines are taken as enabled
  assign per_act = periph_req_i & {extra_timer_irq_enable_ff[2:0],
    capture_unit_irq_enable_b_ff[2:0], {(NPER-6){1'b1}}};
  assign pin_flag = {irq_control_third_ff[`MIEP_C3_I2IF],
                     irq_control_third_ff[`MIEP_C3_I1IF],
                     irq_control_primary_ff[`MIEP_C1_I0IF]};
  assign pin_en = {irq_control_third_ff[`MIEP_C3_I2IE],
                   irq_control_third_ff[`MIEP_C3_I1IE],
                   irq_control_primary_ff[`MIEP_C1_I0IE]};
  assign pin_prio = {irq_control_third_ff[`MIEP_C3_I2IP],
                     irq_control_third_ff[`MIEP_C3_I1IP],
                     1'b1};
  assign t0_req = irq_control_primary_ff[`MIEP_C1_T0IF] &
    irq_control_primary_ff[`MIEP_C1_T0IE];
  assign pc_req = irq_control_primary_ff[`MIEP_C1_PCIF] &
    irq_control_primary_ff[`MIEP_C1_PCIE];

  always @* begin
    nxt_high = 1'b0;
    nxt_low = 1'b0;
    for (i = 0; i < NPER; i = i + 1) begin
      if (per_act[i]) begin
        if (per_prio[i]) begin
          nxt_high = 1'b1;
        end else begin
          nxt_low = 1'b1;
        end
      end
    end
    for (i = 0; i < 3; i = i + 1) begin
      if (pin_flag[i] & pin_en[i]) begin
        if (pin_prio[i]) begin
          nxt_high = 1'b1;
        end else begin
          nxt_low = 1'b1;
        end
      end
    end
    if (t0_req) begin
      if (irq_control_second_ff[`MIEP_C2_T0IP]) begin
        nxt_high = 1'b1;
      end else begin
        nxt_low = 1'b1;
      end
    end
    if (pc_req) begin
      if (irq_control_second_ff[`MIEP_C2_PCIP]) begin
        nxt_high = 1'b1;
      end else begin
        nxt_low = 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      capture_unit_irq_enable_b_ff <= `MIEP_RST_EN;
      extra_timer_irq_enable_ff <= `MIEP_RST_EN;
      irq_priority_select_1_ff <= `MIEP_RST_PRIO1;
      irq_priority_select_2_ff <= `MIEP_RST_PRIO2;
      irq_priority_select_3_ff <= `MIEP_RST_PRIO345;
      irq_priority_select_4_ff <= `MIEP_RST_PRIO345;
      irq_priority_select_5_ff <= `MIEP_RST_PRIO345;
      irq_control_primary_ff <= `MIEP_RST_EN;
      irq_control_second_ff <= `MIEP_RST_CTRL2;
      irq_control_third_ff <= `MIEP_RST_CTRL3;
      per_pin_change_enable_ff <= `MIEP_RST_IOC;
      src_flag_ff <= 6'h00;
      timer_zero_counter_lo_ff <= 8'h00;
      timer_zero_counter_hi_ff <= 8'h00;
      t0_cfg_ff <= 2'b00;
      port_prev_ff <= 4'h0;
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
      wake_o <= 1'b0;
      wake_vector_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ack_o <= (state_ff == ST_IDLE) & cyc_i & stb_i;
      dat_o <= {24'h000000, rd_mux};
      port_prev_ff <= port_b_hi_i;
      irq_high_o <= nxt_high;
      irq_low_o <= nxt_low;
      // wake needs the enable set while asleep; vectoring needs global en
      wake_o <= sleeping_i & |(pin_flag & pin_en);
      wake_vector_o <= sleeping_i & |(pin_flag & pin_en) &
        irq_control_primary_ff[`MIEP_C1_GIEH];
      if (wr_strobe) begin
        case (adr_i)
          `MIEP_ADDR_CAP_EN_B: capture_unit_irq_enable_b_ff <=
            wr_byte & `MIEP_MASK_LOW3;
          `MIEP_ADDR_TMR_EN: extra_timer_irq_enable_ff <=
            wr_byte & `MIEP_MASK_LOW3;
          `MIEP_ADDR_PRIO1: irq_priority_select_1_ff <=
            wr_byte & `MIEP_MASK_PRIO1;
          `MIEP_ADDR_PRIO2: irq_priority_select_2_ff <= wr_byte;
          `MIEP_ADDR_PRIO3: irq_priority_select_3_ff <= wr_byte;
          `MIEP_ADDR_PRIO4: irq_priority_select_4_ff <=
            wr_byte & `MIEP_MASK_LOW3;
          `MIEP_ADDR_PRIO5: irq_priority_select_5_ff <=
            wr_byte & `MIEP_MASK_LOW3;
          `MIEP_ADDR_CTRL2: irq_control_second_ff <=
            wr_byte & `MIEP_MASK_CTRL2;
          `MIEP_ADDR_IOC: per_pin_change_enable_ff <=
            wr_byte & `MIEP_MASK_IOC;
          `MIEP_ADDR_T0CON: t0_cfg_ff <= wr_byte[1:0];
          default: begin
          end
        endcase
      end
      // flag registers: software write first, hardware set wins over clear
      if (wr_strobe && adr_i == `MIEP_ADDR_CTRL1) begin
        irq_control_primary_ff <= wr_byte | {5'b00000,
          t0_ovf, pin_edge[0], port_change};
      end else begin
        irq_control_primary_ff[`MIEP_C1_T0IF] <=
          irq_control_primary_ff[`MIEP_C1_T0IF] | t0_ovf;
        irq_control_primary_ff[`MIEP_C1_I0IF] <=
          irq_control_primary_ff[`MIEP_C1_I0IF] | pin_edge[0];
        irq_control_primary_ff[`MIEP_C1_PCIF] <=
          irq_control_primary_ff[`MIEP_C1_PCIF] | port_change;
      end
      // pin one and two flags follow the same set-wins order
      if (wr_strobe && adr_i == `MIEP_ADDR_CTRL3) begin
        irq_control_third_ff <= (wr_byte & `MIEP_MASK_CTRL3) |
          {6'h00, pin_edge[2], pin_edge[1]};
      end else begin
        irq_control_third_ff[`MIEP_C3_I1IF] <=
          irq_control_third_ff[`MIEP_C3_I1IF] | pin_edge[1];
        irq_control_third_ff[`MIEP_C3_I2IF] <=
          irq_control_third_ff[`MIEP_C3_I2IF] | pin_edge[2];
      end
      // raw event pulses for debug reads: pins, timer zero, port change;
      // not held, since nothing on the bus could ever clear them
      src_flag_ff <= {1'b0, port_change, t0_ovf, pin_edge};
      // a bus load wins over counting in the same cycle
      if (wr_strobe && adr_i == `MIEP_ADDR_TMR0L) begin
        timer_zero_counter_lo_ff <= wr_byte;
      end else if (t0_cfg_ff[`MIEP_T0_RUN]) begin
        timer_zero_counter_lo_ff <= timer_zero_counter_lo_ff + 8'h01;
      end
      if (wr_strobe && adr_i == `MIEP_ADDR_TMR0H) begin
        timer_zero_counter_hi_ff <= wr_byte;
      end else if (t0_cfg_ff[`MIEP_T0_RUN] &
                   t0_cfg_ff[`MIEP_T0_16BIT] &
                   (timer_zero_counter_lo_ff == 8'hFF)) begin
        timer_zero_counter_hi_ff <= timer_zero_counter_hi_ff + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/mieprio_consts.vh ----
`ifndef MIEPRIO_CONSTS_VH
`define MIEPRIO_CONSTS_VH
// register byte addresses on the wishbone slave
`define MIEP_ADDR_CAP_EN_B 6'h00
`define MIEP_ADDR_TMR_EN 6'h04
`define MIEP_ADDR_PRIO1 6'h08
`define MIEP_ADDR_PRIO2 6'h0C
`define MIEP_ADDR_PRIO3 6'h10
`define MIEP_ADDR_PRIO4 6'h14
`define MIEP_ADDR_PRIO5 6'h18
`define MIEP_ADDR_CTRL1 6'h1C
`define MIEP_ADDR_CTRL2 6'h20
`define MIEP_ADDR_CTRL3 6'h24
`define MIEP_ADDR_IOC 6'h28
`define MIEP_ADDR_SRCFLAG 6'h2C
`define MIEP_ADDR_TMR0L 6'h30
`define MIEP_ADDR_TMR0H 6'h34
`define MIEP_ADDR_T0CON 6'h38
`define MIEP_ADDR_REQ 6'h3C
// reset values
`define MIEP_RST_EN 8'h00
`define MIEP_RST_PRIO1 8'h7F
`define MIEP_RST_PRIO2 8'hFF
`define MIEP_RST_PRIO345 8'h00
`define MIEP_RST_CTRL2 8'h75
`define MIEP_RST_CTRL3 8'hC0
`define MIEP_RST_IOC 8'hF0
// implemented bit masks
`define MIEP_MASK_LOW3 8'h07
`define MIEP_MASK_PRIO1 8'h7F
`define MIEP_MASK_CTRL2 8'h75
`define MIEP_MASK_CTRL3 8'hDB
`define MIEP_MASK_IOC 8'hF0
// control register 1 fields
`define MIEP_C1_GIEH 7
`define MIEP_C1_GIEL 6
`define MIEP_C1_T0IE 5
`define MIEP_C1_I0IE 4
`define MIEP_C1_PCIE 3
`define MIEP_C1_T0IF 2
`define MIEP_C1_I0IF 1
`define MIEP_C1_PCIF 0
// control register 2 fields
`define MIEP_C2_EDG0 6
`define MIEP_C2_EDG1 5
`define MIEP_C2_EDG2 4
`define MIEP_C2_T0IP 2
`define MIEP_C2_PCIP 0
// control register 3 fields
`define MIEP_C3_I2IP 7
`define MIEP_C3_I1IP 6
`define MIEP_C3_I2IE 4
`define MIEP_C3_I1IE 3
`define MIEP_C3_I2IF 1
`define MIEP_C3_I1IF 0
// timer zero config: bit 0 selects 16-bit mode, bit 1 runs the counter
`define MIEP_T0_16BIT 0
`define MIEP_T0_RUN 1
`endif

// ---- rtl/miep_edge_det.v ----
`timescale 1ns/100ps
`default_nettype none
// one edge detector per pin; pulse when the selected edge is seen
module miep_edge_det #(
  parameter N = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire [N-1:0] pin_i,
  input wire [N-1:0] rising_i,
  output wire [N-1:0] edge_o
);
  reg [N-1:0] prev_ff;
  genvar g;
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= {N{1'b0}};
    end else begin
      prev_ff <= pin_i;
    end
  end
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pin
      assign edge_o[g] = rising_i[g] ? (pin_i[g] & ~prev_ff[g]) :
                                       (~pin_i[g] & prev_ff[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/miep_ctx_save.v ----
`timescale 1ns/100ps
`default_nettype none
// snapshot of return address and fast-return shadow on interrupt entry
module miep_ctx_save #(
  parameter PCW = 21
) (
  input wire clk_i,
  input wire rst_i,
  input wire entry_i,
  input wire [PCW-1:0] ret_pc_i,
  input wire [7:0] working_register_i,
  input wire [7:0] status_i,
  input wire [7:0] bsr_i,
  output reg push_o,
  output reg [PCW-1:0] push_pc_o,
  output reg [7:0] shadow_working_register_o,
  output reg [7:0] shadow_status_o,
  output reg [7:0] shadow_bsr_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      push_o <= 1'b0;
      push_pc_o <= {PCW{1'b0}};
      shadow_working_register_o <= 8'h00;
      shadow_status_o <= 8'h00;
      shadow_bsr_o <= 8'h00;
    end else begin
      push_o <= entry_i;
      if (entry_i) begin
        push_pc_o <= ret_pc_i;
        // single level: a nested entry overwrites the shadow
        shadow_working_register_o <= working_register_i;
        shadow_status_o <= status_i;
        shadow_bsr_o <= bsr_i;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/miep_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module miep_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_high_i,
  input wire logic irq_low_i,
  input wire logic sleep_req_i,
  input wire logic [28:0] src_i,
  output logic entry_o,
  output logic sleeping_o,
  output logic [20:0] ret_pc_o,
  output logic [7:0] working_register_o,
  output logic [7:0] status_o,
  output logic [7:0] bsr_o,
  output logic [28:0] periph_req_o
);
  logic [1:0] req_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      entry_o <= 1'b0;
      sleeping_o <= 1'b0;
      ret_pc_o <= 21'h01234;
      {working_register_o, status_o, bsr_o} <= 24'hA5C33C;
      periph_req_o <= 29'h0;
      req_ff <= 2'h0;
    end else begin
      req_ff <= {irq_high_i, irq_low_i};
      // one entry per new request while awake; nesting is not modelled
      entry_o <= |({irq_high_i, irq_low_i} & ~req_ff) & !sleeping_o;
      sleeping_o <= sleep_req_i;
      periph_req_o <= src_i;
      // context moves every cycle so a stale capture cannot match
      ret_pc_o <= ret_pc_o + 21'h00003;
      {working_register_o, status_o, bsr_o} <= {status_o ^ 8'h5A, bsr_o + 8'h11, ~working_register_o};
    end
  end
endmodule
`default_nettype wire

// ---- testbench/miep_irq_ctrl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module miep_irq_ctrl_chk #(
  parameter PCW = 21
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic entry_i,
  input wire logic [PCW-1:0] ret_pc_i,
  input wire logic [7:0] working_register_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] bsr_i,
  input wire logic stack_push_o,
  input wire logic [PCW-1:0] stack_pc_o,
  input wire logic [7:0] shadow_working_register_o,
  input wire logic [7:0] shadow_status_o,
  input wire logic [7:0] shadow_bsr_o,
  input wire logic sleeping_i,
  input wire logic wake_o,
  input wire logic wake_vector_o,
  input wire logic irq_high_o,
  input wire logic irq_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_ack = ack_o && !we_i;
  AST_ACK_NEXT: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  AST_EN_HI_ZERO: assert property (
    rd_ack && adr_i inside {6'h00, 6'h04, 6'h14, 6'h18}
    |-> dat_o[7:3] == 5'h00)
    else $error("unimplemented bits read nonzero");
  AST_PRIO1_TOP: assert property (
    rd_ack && adr_i == 6'h08 |-> !dat_o[7])
    else $error("priority one bit 7 set");
  AST_PUSH_PC: assert property (
    entry_i |=> stack_push_o && stack_pc_o == $past(ret_pc_i))
    else $error("return address not pushed");
  AST_SHADOW: assert property (
    entry_i |=> shadow_working_register_o == $past(working_register_i) &&
    shadow_status_o == $past(status_i) && shadow_bsr_o == $past(bsr_i))
    else $error("shadow copy wrong");
  AST_PUSH_CAUSE: assert property (
    stack_push_o |-> $past(entry_i))
    else $error("push without entry");
  AST_SHADOW_HOLD: assert property (
    !entry_i |=> $stable({shadow_working_register_o, shadow_status_o, shadow_bsr_o}))
    else $error("shadow changed without entry");
  AST_WAKE_SLEEP: assert property (
    wake_o |-> $past(sleeping_i))
    else $error("wake while awake");
  AST_RST_QUIET: assert property (
    $past(rst_i) |-> !(irq_high_o || irq_low_o || wake_o || ack_o))
    else $error("output active after reset");
  C_READ: cover property (rd_ack);
  C_LOW_REQ: cover property ($rose(irq_low_o));
  C_WAKE_VEC: cover property (wake_o && wake_vector_o);
endmodule
bind miep_irq_ctrl miep_irq_ctrl_chk #(.PCW(PCW)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .entry_i(entry_i), .ret_pc_i(ret_pc_i),
  .working_register_i(working_register_i), .status_i(status_i), .bsr_i(bsr_i),
  .stack_push_o(stack_push_o), .stack_pc_o(stack_pc_o),
  .shadow_working_register_o(shadow_working_register_o), .shadow_status_o(shadow_status_o),
  .shadow_bsr_o(shadow_bsr_o), .sleeping_i(sleeping_i), .wake_o(wake_o),
  .wake_vector_o(wake_vector_o), .irq_high_o(irq_high_o),
  .irq_low_o(irq_low_o));
`default_nettype wire

// ---- testbench/tb_mcu_interrupt_enable_priority.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_interrupt_enable_priority;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_req = 1'b0;
  logic [5:0] adr_i = 6'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [2:0] ext_pin_i = 3'h0;
  logic [3:0] port_b_hi_i = 4'h0;
  logic [28:0] src = 29'h0, pv, ev;
  logic [31:0] seed = 32'h6CD366E4;
  wire logic [31:0] dat_o;
  wire logic ack_o, irq_high_o, irq_low_o, wake_o, wake_vector_o;
  wire logic stack_push_o, entry_i, sleeping_i;
  wire logic [20:0] ret_pc_i, stack_pc_o;
  wire logic [7:0] working_register_i, status_i, bsr_i;
  wire logic [7:0] shadow_working_register_o, shadow_status_o, shadow_bsr_o;
  wire logic [28:0] periph_req_i;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rq[$];
  logic [20:0] pcq[$];
  logic [5:0] ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18,
                          6'h20, 6'h24, 6'h28};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00,
                          8'h75, 8'hC0, 8'hF0};
  logic [7:0] mk [7] = '{8'h07, 8'h07, 8'h7F, 8'hFF, 8'hFF, 8'h07, 8'h07};

  miep_irq_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_pin_i(ext_pin_i),
    .port_b_hi_i(port_b_hi_i), .periph_req_i(periph_req_i),
    .sleeping_i(sleeping_i), .entry_i(entry_i), .ret_pc_i(ret_pc_i),
    .working_register_i(working_register_i), .status_i(status_i), .bsr_i(bsr_i),
    .irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .wake_o(wake_o),
    .wake_vector_o(wake_vector_o), .stack_push_o(stack_push_o),
    .stack_pc_o(stack_pc_o), .shadow_working_register_o(shadow_working_register_o),
    .shadow_status_o(shadow_status_o), .shadow_bsr_o(shadow_bsr_o));
  miep_core_model i_core (.clk_i(clk_i), .rst_i(rst_i),
    .irq_high_i(irq_high_o), .irq_low_i(irq_low_o), .sleep_req_i(sleep_req),
    .src_i(src), .entry_o(entry_i), .sleeping_o(sleeping_i),
    .ret_pc_o(ret_pc_i), .working_register_o(working_register_i), .status_o(status_i),
    .bsr_o(bsr_i), .periph_req_o(periph_req_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic fail();
    mismatches++;
    complete_run();
  endtask

  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail();
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask

  task automatic settle();
    repeat (5) @(posedge clk_i);
  endtask

  task automatic irq_is(input logic h, input logic l);
    settle();
    check({irq_high_o, irq_low_o}, {h, l});
  endtask

  // clearing flags also re-arms the global and pin enables in one go
  task automatic clr();
    wb(1'b1, 6'h1C, 8'hD0);
    wb(1'b1, 6'h24, 8'h58);
  endtask

  task automatic wait_irq(input logic hi, input int lim);
    int n;
    n = 0;
    while ((hi ? irq_high_o : irq_low_o) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) fail();
    check({irq_high_o, irq_low_o}, {hi, !hi});
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) check(dat_o, rq.pop_front());
    if (stack_push_o === 1'b1) check(stack_pc_o, pcq.pop_front());
    if (entry_i === 1'b1) pcq.push_back(ret_pc_i);
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    for (int k = 0; k < 21; k++) begin
      seed = lfsr(seed);
      wb(1'b1, ra[k % 7], seed[7:0]);
      rd(ra[k % 7], seed[7:0] & mk[k % 7]);
    end
    wb(1'b1, 6'h1C, 8'hC0);
    seed = lfsr(seed);
    for (int i = 0; i < 4; i++) wb(1'b1, ra[i + 2], seed[8*i +: 8]);
    wb(1'b1, 6'h18, {5'h0, seed[29:27]});
    pv = {seed[29:8], seed[6:0]};
    seed = lfsr(seed);
    wb(1'b1, 6'h00, seed[7:0]);
    wb(1'b1, 6'h04, seed[15:8]);
    ev = {seed[10:8], seed[2:0], 23'h7FFFFF};
    for (int i = 0; i < 29; i++) begin
      src <= 29'h1 << i;
      irq_is(pv[i] & ev[i], !pv[i] & ev[i]);
    end
    src <= 29'h0;
    clr();
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 2; s++) begin
        wb(1'b1, 6'h20, 8'h05 | (8'(s) << (6 - p)));
        ext_pin_i[p] <= s[0];
        settle();
        clr();
        ext_pin_i[p] <= !s[0];
        irq_is(1'b0, 1'b0);
        ext_pin_i[p] <= s[0];
        irq_is(p != 2, p == 2);
        clr();
      end
      ext_pin_i[p] <= 1'b0;
    end
    wb(1'b1, 6'h20, 8'h45);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 6'h1C, {k == 2, 2'h0, k != 0, 4'h0});
      sleep_req <= 1'b1;
      ext_pin_i[0] <= 1'b1;
      irq_is(k != 0, 1'b0);
      check({wake_o, wake_vector_o}, {k != 0, k == 2});
      sleep_req <= 1'b0;
      ext_pin_i[0] <= 1'b0;
      clr();
    end
    wb(1'b1, 6'h20, 8'h01);
    wb(1'b1, 6'h1C, 8'hE0);
    wb(1'b1, 6'h30, 8'hF8);
    wb(1'b1, 6'h38, 8'h02);
    wait_irq(1'b0, 30);
    wb(1'b1, 6'h38, 8'h00);
    wb(1'b1, 6'h1C, 8'hE0);
    irq_is(1'b0, 1'b0);
    wb(1'b1, 6'h20, 8'h05);
    wb(1'b1, 6'h34, 8'hFE);
    wb(1'b1, 6'h30, 8'hF8);
    wb(1'b1, 6'h38, 8'h03);
    // an 8-bit rollover would already have fired here
    repeat (8) irq_is(1'b0, 1'b0);
    wait_irq(1'b1, 400);
    wb(1'b1, 6'h38, 8'h00);
    wb(1'b1, 6'h1C, 8'hC8);
    wb(1'b1, 6'h20, 8'h04);
    wb(1'b1, 6'h28, 8'h20);
    port_b_hi_i[0] <= 1'b1;
    irq_is(1'b0, 1'b0);
    port_b_hi_i[1] <= 1'b1;
    irq_is(1'b0, 1'b1);
    // request lines read back: low only; an unaligned address reads zero
    rd(6'h3C, 8'h02);
    rd(6'h3D, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
